// ===== core/pir_regs.sv
// Management register block with event flags, enables and frame checker counters
`timescale 1ns/1ps

module pir_regs (
    input  logic               CLOCK,
    input  logic               ARST_N,
    input  logic               MDC,
    input  logic               MDIO_IN,
    output logic               MDIO_OUT,
    output logic               MDIO_OE,
    input  logic [4:0]         PHY_ADDR,
    input  pir_pkg::pir_stream_t MAC_STREAM,
    input  pir_pkg::pir_stream_t LINE_STREAM,
    input  logic               LOOPBACK_EN,
    input  logic               BUF_ERR_EVENT,
    input  logic               NEG_CHANGE_EVENT,
    input  logic               LINK_CHANGE_EVENT,
    input  logic [15:0]        FAULT_EVENTS,
    output logic               IRQ,
    output logic               FATAL_ERROR
);
    import pir_pkg::*;

    logic [1:0]            rst_pipe_reg;
    logic                  rst_n;
    logic [2:0]            mdc_pipe_reg;
    logic [1:0]            mdio_pipe_reg;
    logic [4:0]            phy_pipe0_reg;
    logic [4:0]            phy_pipe1_reg;
    logic                  mdc_rise;
    logic                  mdio_bit;

    pir_mdio_state_t       state_reg;
    logic [5:0]            ones_reg;
    logic [3:0]            cnt_reg;
    logic [13:0]           hdr_reg;
    logic [15:0]           dsh_reg;
    logic [15:0]           rd_data_reg;
    logic                  oe_reg;
    logic                  out_reg;
    logic [15:0]           addr_reg;

    logic                  frame_match;
    logic                  is_read;
    logic                  rd_fire;
    logic                  end_fire;
    logic                  wr_fire;
    logic [15:0]           wr_word;
    logic [1:0]            op;

    logic [15:0]           flags_reg;
    logic [15:0]           flags_next;
    logic [15:0]           enables_reg;
    logic [15:0]           enables_next;
    logic                  chk_en_reg;
    logic                  chk_irq_reg;
    logic                  path_reg;
    logic                  irq_reg;
    logic                  fatal_reg;
    logic [15:0]           ev_vec;
    logic                  flags_clr;

    pir_stream_t           src;
    logic                  frame_seen;
    logic                  err_hit;
    logic                  tally_rd;
    logic [15:0]           tally_reg;
    logic [15:0]           tally_next;
    logic [31:0]           frames_reg;
    logic [31:0]           frames_copy_reg;
    logic [15:0]           kind_cnt_reg  [NUM_KINDS];
    logic [15:0]           kind_copy_reg [NUM_KINDS];
    logic [15:0]           kind_sel      [NUM_KINDS];
    logic [15:0]           kind_word;
    logic [15:0]           rd_word;

    // Reset release and input synchronisers
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_pipe_reg <= 2'h0;
        end else begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_reg[1];

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            mdc_pipe_reg  <= 3'h0;
            mdio_pipe_reg <= 2'h3;
            phy_pipe0_reg <= 5'h00;
            phy_pipe1_reg <= 5'h00;
        end else begin
            mdc_pipe_reg  <= {mdc_pipe_reg[1:0], MDC};
            mdio_pipe_reg <= {mdio_pipe_reg[0], MDIO_IN};
            phy_pipe0_reg <= PHY_ADDR;
            phy_pipe1_reg <= phy_pipe0_reg;
        end
    end
    assign mdc_rise = mdc_pipe_reg[1] & ~mdc_pipe_reg[2];
    assign mdio_bit = mdio_pipe_reg[1];

    // Frame decode
    assign op          = hdr_reg[11:10];
    assign frame_match = (hdr_reg[13:12] == ST_C45) && (hdr_reg[9:5] == phy_pipe1_reg)
                         && (hdr_reg[4:0] == DEVAD);
    assign is_read     = frame_match && op[1];
    assign rd_fire     = mdc_rise && (state_reg == S_TA) && (cnt_reg == 4'h0) && is_read;
    assign end_fire    = mdc_rise && (state_reg == S_DATA) && (cnt_reg == DATA_LAST)
                         && frame_match;
    assign wr_fire     = end_fire && (op == OP_WRITE);
    assign wr_word     = {dsh_reg[14:0], mdio_bit};

    // Management frame engine
    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            state_reg   <= S_PRE;
            ones_reg    <= 6'h00;
            cnt_reg     <= 4'h0;
            hdr_reg     <= 14'h0000;
            dsh_reg     <= 16'h0000;
            rd_data_reg <= 16'h0000;
            oe_reg      <= 1'b0;
            out_reg     <= 1'b0;
        end else if (mdc_rise) begin
            case (state_reg)
                S_PRE: begin
                    if (mdio_bit) begin
                        if (ones_reg != PREAMBLE_LEN) begin
                            ones_reg <= ones_reg + 6'h01;
                        end
                    end else begin
                        ones_reg <= 6'h00;
                        if (ones_reg == PREAMBLE_LEN) begin
                            state_reg <= S_HDR;
                            hdr_reg   <= 14'h0000;
                            cnt_reg   <= 4'h1;
                        end
                    end
                end
                S_HDR: begin
                    hdr_reg <= {hdr_reg[12:0], mdio_bit};
                    cnt_reg <= cnt_reg + 4'h1;
                    if (cnt_reg == HDR_LAST) begin
                        state_reg <= S_TA;
                        cnt_reg   <= 4'h0;
                    end
                end
                S_TA: begin
                    if (cnt_reg == 4'h0) begin
                        cnt_reg <= 4'h1;
                        if (is_read) begin
                            oe_reg      <= 1'b1;
                            out_reg     <= 1'b0;
                            rd_data_reg <= rd_word;
                        end
                    end else begin
                        state_reg <= S_DATA;
                        cnt_reg   <= 4'h0;
                        out_reg   <= rd_data_reg[15];
                    end
                end
                S_DATA: begin
                    dsh_reg     <= wr_word;
                    cnt_reg     <= cnt_reg + 4'h1;
                    out_reg     <= rd_data_reg[14];
                    rd_data_reg <= {rd_data_reg[14:0], 1'b0};
                    if (cnt_reg == DATA_LAST) begin
                        state_reg <= S_PRE;
                        oe_reg    <= 1'b0;
                        out_reg   <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= S_PRE;
                end
            endcase
        end
    end
    assign MDIO_OE  = oe_reg;
    assign MDIO_OUT = out_reg & oe_reg;

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            addr_reg <= 16'h0000;
        end else if (end_fire && (op == OP_ADDR)) begin
            addr_reg <= wr_word;
        end else if (end_fire && (op == OP_READ_INC)) begin
            addr_reg <= addr_reg + 16'h0001;
        end
    end

    // Frame checker source and counting
    assign src = path_reg ? (LOOPBACK_EN ? LINE_STREAM : MAC_STREAM) : LINE_STREAM;
    assign frame_seen = chk_en_reg && src.frame_end;
    assign err_hit    = frame_seen && (src.crc_err || (|src.kind_err));
    assign tally_rd   = rd_fire && (addr_reg == ADDR_ERR_TALLY);
    assign tally_next = tally_rd ? {15'h0000, err_hit} : tally_reg + {15'h0000, err_hit};

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            tally_reg       <= 16'h0000;
            frames_reg      <= 32'h0000_0000;
            frames_copy_reg <= 32'h0000_0000;
        end else begin
            tally_reg  <= tally_next;
            frames_reg <= frames_reg + {31'h0000_0000, frame_seen};
            if (tally_rd) begin
                frames_copy_reg <= frames_reg;
            end
        end
    end

    genvar k;
    generate
        for (k = 0; k < NUM_KINDS; k = k + 1) begin : g_kind
            always_ff @(posedge CLOCK or negedge rst_n) begin
                if (!rst_n) begin
                    kind_cnt_reg[k]  <= 16'h0000;
                    kind_copy_reg[k] <= 16'h0000;
                end else begin
                    kind_cnt_reg[k] <= kind_cnt_reg[k]
                                       + {15'h0000, frame_seen && src.kind_err[k]};
                    if (tally_rd) begin
                        kind_copy_reg[k] <= kind_cnt_reg[k];
                    end
                end
            end
            assign kind_sel[k] = (addr_reg == ADDR_KIND[k]) ? kind_copy_reg[k] : 16'h0000;
        end
    endgenerate

    always_comb begin
        kind_word = 16'h0000;
        for (int i = 0; i < NUM_KINDS; i++) begin
            kind_word = kind_word | kind_sel[i];
        end
    end

    // Event flags and enables
    always_comb begin
        ev_vec               = FAULT_EVENTS & RSV_MASK;
        ev_vec[BIT_CHK_EVT]  = err_hit && chk_irq_reg;
        ev_vec[BIT_BUF_EVT]  = BUF_ERR_EVENT;
        ev_vec[BIT_NEG_EVT]  = NEG_CHANGE_EVENT;
        ev_vec[BIT_LINK_EVT] = LINK_CHANGE_EVENT;
    end
    assign flags_clr    = rd_fire && (addr_reg == ADDR_FLAGS);
    assign flags_next   = (flags_clr ? 16'h0000 : flags_reg) | ev_vec;
    assign enables_next = (wr_fire && (addr_reg == ADDR_ENABLES)) ? wr_word
                          : (enables_reg & ~ENABLES_SC);

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            flags_reg   <= RST_FLAGS;
            enables_reg <= RST_ENABLES;
            irq_reg     <= 1'b0;
            fatal_reg   <= 1'b0;
        end else begin
            flags_reg   <= flags_next;
            enables_reg <= enables_next;
            irq_reg     <= |(flags_reg & enables_reg);
            fatal_reg   <= |(flags_reg & RSV_MASK);
        end
    end
    assign IRQ         = irq_reg;
    assign FATAL_ERROR = fatal_reg;

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            chk_en_reg  <= RST_CHK_EN;
            chk_irq_reg <= RST_CHK_IRQ;
            path_reg    <= RST_PATH;
        end else if (wr_fire) begin
            if (addr_reg == ADDR_CHK_EN) begin
                chk_en_reg <= wr_word[0];
            end
            if (addr_reg == ADDR_CHK_IRQ) begin
                chk_irq_reg <= wr_word[0];
            end
            if (addr_reg == ADDR_PATH) begin
                path_reg <= wr_word[0];
            end
        end
    end

    // Read data selection
    assign rd_word = (addr_reg == ADDR_PRESENCE)  ? RST_PRESENCE :
                     (addr_reg == ADDR_FLAGS)     ? flags_reg :
                     (addr_reg == ADDR_ENABLES)   ? enables_reg :
                     (addr_reg == ADDR_CHK_EN)    ? {15'h0000, chk_en_reg} :
                     (addr_reg == ADDR_CHK_IRQ)   ? {15'h0000, chk_irq_reg} :
                     (addr_reg == ADDR_PATH)      ? {15'h0000, path_reg} :
                     (addr_reg == ADDR_ERR_TALLY) ? tally_reg :
                     (addr_reg == ADDR_FRAME_HI)  ? frames_copy_reg[31:16] :
                     (addr_reg == ADDR_FRAME_LO)  ? frames_copy_reg[15:0] :
                     kind_word;

endmodule

// ===== shared/pir_pkg.sv
// Package of constants and types for the PHY event flag and frame checker register block
package pir_pkg;

    // Management frame decode
    localparam logic [4:0]  DEVAD          = 5'h1f;
    localparam logic [1:0]  ST_C45         = 2'h0;
    localparam logic [1:0]  OP_ADDR        = 2'h0;
    localparam logic [1:0]  OP_WRITE       = 2'h1;
    localparam logic [1:0]  OP_READ_INC    = 2'h2;
    localparam logic [5:0]  PREAMBLE_LEN   = 6'h20;
    localparam logic [3:0]  HDR_LAST       = 4'hd;
    localparam logic [3:0]  DATA_LAST      = 4'hf;

    // Register offsets
    localparam logic [15:0] ADDR_PRESENCE  = 16'h0008;
    localparam logic [15:0] ADDR_FLAGS     = 16'h0011;
    localparam logic [15:0] ADDR_ENABLES   = 16'h0021;
    localparam logic [15:0] ADDR_CHK_EN    = 16'h8001;
    localparam logic [15:0] ADDR_CHK_IRQ   = 16'h8004;
    localparam logic [15:0] ADDR_PATH      = 16'h8005;
    localparam logic [15:0] ADDR_ERR_TALLY = 16'h8008;
    localparam logic [15:0] ADDR_FRAME_HI  = 16'h8009;
    localparam logic [15:0] ADDR_FRAME_LO  = 16'h800a;

    // Frame error kinds: length, alignment, symbol, oversize, undersize,
    // odd nibble, odd preamble, false carrier
    localparam int          NUM_KINDS      = 8;
    localparam logic [15:0] ADDR_KIND [NUM_KINDS] = '{
        16'h800b, 16'h800c, 16'h800d, 16'h800e,
        16'h800f, 16'h8010, 16'h8011, 16'h8013
    };

    // Reset values
    localparam logic [15:0] RST_PRESENCE   = 16'h8000;
    localparam logic [15:0] RST_FLAGS      = 16'h0000;
    localparam logic [15:0] RST_ENABLES    = 16'h2402;
    localparam logic        RST_CHK_EN     = 1'h1;
    localparam logic        RST_CHK_IRQ    = 1'h1;
    localparam logic        RST_PATH       = 1'h0;

    // Flag positions
    localparam int          BIT_CHK_EVT    = 14;
    localparam int          BIT_BUF_EVT    = 13;
    localparam int          BIT_NEG_EVT    = 11;
    localparam int          BIT_LINK_EVT   = 1;
    localparam logic [15:0] RSV_MASK       = 16'h97fd;
    localparam logic [15:0] ENABLES_SC     = 16'h8000;

    typedef struct packed {
        logic                 frame_end;
        logic                 crc_err;
        logic [NUM_KINDS-1:0] kind_err;
    } pir_stream_t;

    typedef enum {S_PRE, S_HDR, S_TA, S_DATA} pir_mdio_state_t;

endpackage

// ===== test/pir_mdio_host.sv
// Management host model that issues Clause 45 frames on MDC and MDIO
`timescale 1ns/1ps
module pir_mdio_host (
    input  wire logic clk,
    input  wire logic mdio_out,
    input  wire logic mdio_oe,
    output logic      mdc,
    output wire logic mdio_in
);
    import pir_pkg::*;
    logic drv_en;
    logic drv_val;
    // Released line floats high through the pull-up
    assign mdio_in = mdio_oe ? mdio_out : (drv_en ? drv_val : 1'b1);
    initial begin
        mdc = 1'b0;
        drv_en = 1'b0;
        drv_val = 1'b1;
    end
    // One MDC period of ten clocks, MDIO changes while MDC is low
    task automatic bit_io(input logic b, input logic en, output logic s);
        drv_en = en;
        drv_val = b;
        repeat (5) @(negedge clk);
        s = mdio_in;
        mdc = 1'b1;
        repeat (5) @(negedge clk);
        mdc = 1'b0;
    endtask
    // Read frames release the line from the first turnaround bit on
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [15:0] d,
                         output logic [15:0] q);
        logic        s;
        logic [31:0] w;
        w = {ST_C45, op, pa, DEVAD, 2'h2, d};
        for (int i = 0; i < 32; i++) bit_io(1'b1, 1'b1, s);
        for (int i = 31; i >= 0; i--) begin
            bit_io(w[i], !(op[1] && i < 18), s);
            if (i < 16) q[i] = s;
        end
        drv_en = 1'b0;
    endtask
endmodule

// ===== test/pir_regs_sva.sv
// Pin-level assertions for the event flag and checker register block
`timescale 1ns/1ps
module pir_regs_sva
    import pir_pkg::*;
(
    input wire logic        CLOCK,
    input wire logic        ARST_N,
    input wire logic        MDC,
    input wire logic        MDIO_OUT,
    input wire logic        MDIO_OE,
    input wire logic        BUF_ERR_EVENT,
    input wire logic        NEG_CHANGE_EVENT,
    input wire logic        LINK_CHANGE_EVENT,
    input wire logic [15:0] FAULT_EVENTS,
    input wire pir_pkg::pir_stream_t MAC_STREAM,
    input wire pir_pkg::pir_stream_t LINE_STREAM,
    input wire logic        IRQ,
    input wire logic        FATAL_ERROR
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);
    logic       mdc_q;
    logic [4:0] rise_cnt;
    logic [3:0] quiet;
    wire        fault = |(FAULT_EVENTS & RSV_MASK);
    wire        act = MDC | fault | BUF_ERR_EVENT | NEG_CHANGE_EVENT | LINK_CHANGE_EVENT
                      | MAC_STREAM.frame_end | LINE_STREAM.frame_end;
    // MDC rises while driving, and cycles since the last possible cause
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            mdc_q <= 1'b0;
            rise_cnt <= 5'h00;
            quiet <= 4'hf;
        end else begin
            mdc_q <= MDC;
            rise_cnt <= !MDIO_OE ? 5'h00 : rise_cnt + 5'(MDC && !mdc_q);
            quiet <= act ? 4'h0 : quiet + 4'(quiet != 4'hf);
        end
    end
    chk_fatal_raise: assert property (fault |-> ##[1:3] FATAL_ERROR)
        else $error("fatal flag missed a reserved event");
    chk_fatal_hold: assert property (FATAL_ERROR && !MDIO_OE |=> FATAL_ERROR || MDIO_OE)
        else $error("fatal flag dropped without a read");
    chk_fatal_drop: assert property ($fell(FATAL_ERROR) |-> $past(MDIO_OE))
        else $error("fatal flag cleared outside a read");
    chk_fatal_cause: assert property ($rose(FATAL_ERROR) |->
        $past(fault) || $past(fault, 2) || $past(fault, 3))
        else $error("fatal flag rose with no reserved event");
    chk_irq_cause: assert property ($rose(IRQ) |-> quiet <= 4'h6)
        else $error("interrupt rose with no event or write");
    chk_out_gated: assert property (!MDIO_OE |-> !MDIO_OUT)
        else $error("data driven while output disabled");
    chk_oe_cause: assert property ($rose(MDIO_OE) |-> quiet <= 4'h6)
        else $error("line driven outside a frame");
    chk_oe_length: assert property ($fell(MDIO_OE) |-> rise_cnt == 5'h11)
        else $error("read answer not turnaround plus sixteen bits");
    cover property (fault ##[1:3] FATAL_ERROR);
    cover property ($rose(IRQ));
    cover property ($fell(MDIO_OE));
endmodule
bind pir_regs pir_regs_sva pir_regs_sva_i (.CLOCK, .ARST_N, .MDC, .MDIO_OUT, .MDIO_OE,
    .BUF_ERR_EVENT, .NEG_CHANGE_EVENT, .LINK_CHANGE_EVENT, .FAULT_EVENTS, .MAC_STREAM,
    .LINE_STREAM, .IRQ, .FATAL_ERROR);

// ===== test/pir_regs_tb.sv
// Self-checking bench for the event flag and checker register block
`timescale 1ns/1ps
module pir_regs_tb;
    import pir_pkg::*;
    logic        clock;
    logic        arst_n;
    logic        mdc;
    logic        mdio_in;
    logic        mdio_out;
    logic        mdio_oe;
    pir_stream_t mac_s;
    pir_stream_t line_s;
    logic        loop_en;
    logic [2:0]  ev;
    logic [15:0] fault;
    logic        irq;
    logic        fatal;
    logic [15:0] q;
    int          bad_count;
    int          compares;
    int          cycles;
    pir_regs pir_regs_i (.CLOCK(clock), .ARST_N(arst_n), .MDC(mdc), .MDIO_IN(mdio_in),
        .MDIO_OUT(mdio_out), .MDIO_OE(mdio_oe), .PHY_ADDR(5'h05), .MAC_STREAM(mac_s),
        .LINE_STREAM(line_s), .LOOPBACK_EN(loop_en), .BUF_ERR_EVENT(ev[2]),
        .NEG_CHANGE_EVENT(ev[1]), .LINK_CHANGE_EVENT(ev[0]), .FAULT_EVENTS(fault),
        .IRQ(irq), .FATAL_ERROR(fatal));
    pir_mdio_host pir_mdio_host_i (.clk(clock), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
        .mdc(mdc), .mdio_in(mdio_in));
    task automatic give_verdict;
        $display("Mismatches %0d of %0d comparisons", bad_count, compares);
        if (bad_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        pir_mdio_host_i.frame(OP_ADDR, 5'h05, a, q);
        pir_mdio_host_i.frame(OP_WRITE, 5'h05, d, q);
    endtask
    task automatic rd(input logic [15:0] a);
        pir_mdio_host_i.frame(OP_ADDR, 5'h05, a, q);
        pir_mdio_host_i.frame(2'h3, 5'h05, 16'h0000, q);
    endtask
    task automatic pulse(input logic [2:0] e, input logic [15:0] f);
        @(negedge clock) ev = e;
        fault = f;
        @(negedge clock) ev = 3'h0;
        fault = 16'h0000;
        repeat (3) @(negedge clock);
    endtask
    task automatic frm(input logic mac, input logic crc, input logic [7:0] k);
        @(negedge clock) if (mac) mac_s = {1'b1, crc, k}; else line_s = {1'b1, crc, k};
        @(negedge clock) mac_s = '0;
        line_s = '0;
        repeat (3) @(negedge clock);
    endtask
    task automatic s_reset;
        logic [15:0] adr [8] = '{ADDR_PRESENCE, ADDR_FLAGS, ADDR_ENABLES, ADDR_CHK_EN,
                                 ADDR_CHK_IRQ, ADDR_PATH, ADDR_ERR_TALLY, 16'h8012};
        logic [15:0] exp [8] = '{16'h8000, 16'h0000, 16'h2402, 16'h0001,
                                 16'h0001, 16'h0000, 16'h0000, 16'h0000};
        for (int i = 0; i < 8; i++) begin
            rd(adr[i]);
            check("reset value", exp[i], q);
        end
    endtask
    task automatic s_flags;
        pulse(3'h0, 16'h97fd);
        check("fatal", 16'h0001, 16'(fatal));
        rd(ADDR_FLAGS);
        check("reserved flags", 16'h97fd, q);
        pulse(3'h7, 16'h0000);
        check("irq", 16'h0001, 16'(irq));
        check("fatal after read", 16'h0000, 16'(fatal));
        rd(ADDR_FLAGS);
        check("event flags", 16'h2802, q);
        rd(ADDR_FLAGS);
        check("flags cleared", 16'h0000, q);
        check("irq cleared", 16'h0000, 16'(irq));
        // Link event lands in the very cycle the flag read clears the register
        fork
            rd(ADDR_FLAGS);
            begin
                repeat (111) @(posedge mdc);
                repeat (2) @(negedge clock);
                ev = 3'h1;
                @(negedge clock) ev = 3'h0;
            end
        join
        check("read beside event", 16'h0000, q);
        rd(ADDR_FLAGS);
        check("event kept", 16'h0002, q);
    endtask
    task automatic s_mask;
        wr(ADDR_ENABLES, 16'h8800);
        rd(ADDR_ENABLES);
        check("enables", 16'h0800, q);
        pulse(3'h5, 16'h0000);
        check("irq masked", 16'h0000, 16'(irq));
        pulse(3'h2, 16'h0000);
        check("irq unmasked", 16'h0001, 16'(irq));
        rd(ADDR_FLAGS);
        check("masked flags", 16'h2802, q);
    endtask
    task automatic s_checker;
        wr(ADDR_ENABLES, 16'h4000);
        frm(1'b0, 1'b0, 8'h00);
        check("irq good frame", 16'h0000, 16'(irq));
        frm(1'b0, 1'b1, 8'h00);
        check("irq crc frame", 16'h0001, 16'(irq));
        frm(1'b0, 1'b0, 8'h01);
        frm(1'b1, 1'b1, 8'h00);
        rd(ADDR_ERR_TALLY);
        check("error tally", 16'h0002, q);
        pir_mdio_host_i.frame(OP_ADDR, 5'h05, ADDR_FRAME_HI, q);
        pir_mdio_host_i.frame(OP_READ_INC, 5'h05, 16'h0000, q);
        check("frame copy high", 16'h0000, q);
        pir_mdio_host_i.frame(2'h3, 5'h05, 16'h0000, q);
        check("frame copy low", 16'h0003, q);
        rd(ADDR_KIND[0]);
        check("length copy", 16'h0001, q);
        rd(ADDR_ERR_TALLY);
        check("tally cleared", 16'h0000, q);
        rd(ADDR_FLAGS);
        check("checker flag", 16'h4000, q);
    endtask
    task automatic s_path;
        wr(ADDR_PATH, 16'h0001);
        frm(1'b1, 1'b1, 8'h00);
        frm(1'b0, 1'b1, 8'h00);
        @(negedge clock) loop_en = 1'b1;
        frm(1'b0, 1'b1, 8'h00);
        frm(1'b1, 1'b1, 8'h00);
        @(negedge clock) loop_en = 1'b0;
        rd(ADDR_FLAGS);
        check("path flag", 16'h4000, q);
        wr(ADDR_CHK_IRQ, 16'h0000);
        frm(1'b1, 1'b1, 8'h00);
        wr(ADDR_CHK_EN, 16'h0000);
        frm(1'b1, 1'b1, 8'h00);
        rd(ADDR_ERR_TALLY);
        check("path tally", 16'h0003, q);
        rd(ADDR_FLAGS);
        check("no checker flag", 16'h0000, q);
    endtask
    task automatic s_foreign;
        pir_mdio_host_i.frame(2'h3, 5'h06, 16'h0000, q);
        check("foreign port read", 16'hffff, q);
    endtask
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            bad_count++;
            give_verdict();
        end
    end
    initial begin
        arst_n = 1'b0;
        mac_s = '0;
        line_s = '0;
        loop_en = 1'b0;
        ev = 3'h0;
        fault = 16'h0000;
        repeat (16) @(negedge clock);
        arst_n = 1'b1;
        repeat (4) @(negedge clock);
        s_reset();
        s_flags();
        s_mask();
        s_checker();
        s_path();
        s_foreign();
        give_verdict();
    end
endmodule
